// *** dol_pkg.sv ***
// Package with register map, field layout and reset values of the offset loop configuration.
package dol_pkg;
	localparam int DOL_ADDR_W = 6;
	localparam int DOL_DATA_W = 8;
	localparam logic [5:0] DOL_FREQ_CFG_ADDR = 6'h19;
	localparam logic [5:0] DOL_BSYNC_CFG_ADDR = 6'h18;
	localparam logic [7:0] DOL_FREQ_CFG_RST = 8'h36;
	localparam logic [7:0] DOL_BSYNC_CFG_RST = 8'h6C;
	localparam logic [7:0] DOL_FREQ_CFG_MASK = 8'h3F;
	// Fields of freq_offset_comp_config.
	localparam int DOL_GATE_BIT = 5;
	localparam int DOL_FPRE_LSB = 3;
	localparam int DOL_FPOST_BIT = 2;
	localparam int DOL_FLIM_LSB = 0;
	// Fields of bit_sync_config.
	localparam int DOL_IPRE_LSB = 6;
	localparam int DOL_PPRE_LSB = 4;
	localparam int DOL_IPOST_BIT = 3;
	localparam int DOL_PPOST_BIT = 2;
	localparam int DOL_RLIM_LSB = 0;
	// Frequency and integral gain outputs in halves of the base gain; the halved post-sync gain is one unit.
	localparam logic [3:0] DOL_HALF_GAIN = 4'h1;
	localparam logic [2:0] DOL_UNIT_GAIN = 3'h1;
	localparam int DOL_RSSI_W = 8;
endpackage

// *** dol_carrier_sense.sv ***
// Carrier sense detector with absolute and relative signal strength thresholds.
module dol_carrier_sense #(
	parameter int RSSI_W = dol_pkg::DOL_RSSI_W
) (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic rx_start_i,
	input wire logic rssi_valid_i,
	input wire logic signed [RSSI_W-1:0] rssi_i,
	input wire logic signed [RSSI_W-1:0] cs_abs_thr_i,
	input wire logic [RSSI_W-1:0] cs_rel_thr_i,
	output logic carrier_sense_o
);
	typedef struct packed {
		logic signed [RSSI_W-1:0] ref_lvl;
		logic cs;
	} dol_cs_s;

	dol_cs_s st_r;
	dol_cs_s st_nxt;
	logic signed [RSSI_W:0] rise;

	// The reference is the level at reception start, so a rise is measured against the floor.
	always_comb begin
		st_nxt = st_r;
		rise = (RSSI_W+1)'(rssi_i) - (RSSI_W+1)'(st_r.ref_lvl);
		if (rx_start_i) begin
			st_nxt.ref_lvl = rssi_i;
			st_nxt.cs = 1'b0;
		end else if (rssi_valid_i) begin
			st_nxt.cs = (rssi_i > cs_abs_thr_i) ||
				((cs_rel_thr_i != '0) && (rise >= $signed({1'b0, cs_rel_thr_i}))); // [R11]
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign carrier_sense_o = st_r.cs;

	property p_cs_abs;
		@(posedge mclk_i) disable iff (!rst_b_i)
		(rssi_valid_i && !rx_start_i && (rssi_i > cs_abs_thr_i)) |=> carrier_sense_o;
	endproperty
	a_cs_abs: assert property (p_cs_abs) else $error("carrier sense missed absolute threshold"); // [R11]
endmodule

// *** dol_offset_loop_cfg.sv ***
// Frequency offset and clock recovery loop configuration with sync-dependent gain selection.
// How it works
// R1: With gating set, both loops stay frozen until carrier sense goes high.
// R2: Pre-sync frequency gain is K, 2K, 3K or 4K; reset code 10.
// R3: Post-sync frequency gain keeps pre value or becomes K/2; bit resets to 1.
// R4: Frequency offset clamp is 0, BW/8, BW/4, BW/2; code 00 disables; reset 10.
// R5: Software must choose limit code 00 whenever on-off keying is used.
// R6: Pre-sync integral gain is KI to 4KI; reset code 01.
// R7: Pre-sync proportional gain is KP to 4KP; reset code 10.
// R8: Post-sync integral gain keeps pre value or becomes KI/2; bit resets to 1.
// R9: Post-sync proportional gain keeps pre value or becomes KP; bit resets to 1.
// R10: Data rate clamp is 0, 3.125, 6.25 or 12.5 percent; reset code 00.
// R11: Carrier sense rises on absolute threshold or relative rise of signal strength.
// R12: Post-sync gains apply in the sync detect cycle, revert at reception start.
module dol_offset_loop_cfg #(
	parameter int RSSI_W = dol_pkg::DOL_RSSI_W
) (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic [dol_pkg::DOL_ADDR_W-1:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [dol_pkg::DOL_DATA_W-1:0] reg_wdata_i,
	output logic [dol_pkg::DOL_DATA_W-1:0] reg_rdata_o,
	input wire logic rx_start_i,
	input wire logic sync_det_i,
	input wire logic rssi_valid_i,
	input wire logic signed [RSSI_W-1:0] rssi_i,
	input wire logic signed [RSSI_W-1:0] cs_abs_thr_i,
	input wire logic [RSSI_W-1:0] cs_rel_thr_i,
	output logic carrier_sense_o,
	output logic loops_run_o,
	output logic post_sync_o,
	output logic [3:0] freq_gain_o,
	output logic freq_comp_en_o,
	output logic [1:0] freq_limit_log2_o,
	output logic [3:0] clk_int_gain_o,
	output logic [2:0] clk_prop_gain_o,
	output logic [2:0] rate_limit_o
);
	typedef struct packed {
		logic [7:0] freq_cfg;
		logic [7:0] bsync_cfg;
		logic synced;
		logic [7:0] rdata;
	} dol_state_s;

	dol_state_s st_r;
	dol_state_s st_nxt;
	logic cs;
	logic loop_gate_on_carrier;
	logic [1:0] freq_gain_pre_sync;
	logic freq_gain_post_sync;
	logic [1:0] freq_offset_limit;
	logic [1:0] clk_integral_gain_pre_sync;
	logic [1:0] clk_proportional_gain_pre_sync;
	logic clk_integral_gain_post_sync;
	logic clk_proportional_gain_post_sync;
	logic [1:0] data_rate_offset_limit;
	logic post_active;
	logic [3:0] freq_pre_units;
	logic [3:0] int_pre_units;
	logic [2:0] prop_pre_units;

	dol_carrier_sense #(
		.RSSI_W(RSSI_W)
	) u_cs (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.rx_start_i(rx_start_i),
		.rssi_valid_i(rssi_valid_i),
		.rssi_i(rssi_i),
		.cs_abs_thr_i(cs_abs_thr_i),
		.cs_rel_thr_i(cs_rel_thr_i),
		.carrier_sense_o(cs)
	);

	assign loop_gate_on_carrier = st_r.freq_cfg[dol_pkg::DOL_GATE_BIT];
	assign freq_gain_pre_sync = st_r.freq_cfg[dol_pkg::DOL_FPRE_LSB +: 2];
	assign freq_gain_post_sync = st_r.freq_cfg[dol_pkg::DOL_FPOST_BIT];
	assign freq_offset_limit = st_r.freq_cfg[dol_pkg::DOL_FLIM_LSB +: 2];
	assign clk_integral_gain_pre_sync = st_r.bsync_cfg[dol_pkg::DOL_IPRE_LSB +: 2];
	assign clk_proportional_gain_pre_sync = st_r.bsync_cfg[dol_pkg::DOL_PPRE_LSB +: 2];
	assign clk_integral_gain_post_sync = st_r.bsync_cfg[dol_pkg::DOL_IPOST_BIT];
	assign clk_proportional_gain_post_sync = st_r.bsync_cfg[dol_pkg::DOL_PPOST_BIT];
	assign data_rate_offset_limit = st_r.bsync_cfg[dol_pkg::DOL_RLIM_LSB +: 2];

	always_comb begin
		st_nxt = st_r;
		if (reg_wr_i && (reg_addr_i == dol_pkg::DOL_FREQ_CFG_ADDR)) begin
			st_nxt.freq_cfg = reg_wdata_i & dol_pkg::DOL_FREQ_CFG_MASK;
		end
		if (reg_wr_i && (reg_addr_i == dol_pkg::DOL_BSYNC_CFG_ADDR)) begin
			st_nxt.bsync_cfg = reg_wdata_i;
		end
		// A sync event in the same cycle as a new reception wins, so it is never lost.
		if (sync_det_i) begin
			st_nxt.synced = 1'b1; // [R12]
		end else if (rx_start_i) begin
			st_nxt.synced = 1'b0; // [R12]
		end
		unique case (reg_addr_i)
			dol_pkg::DOL_FREQ_CFG_ADDR: st_nxt.rdata = st_r.freq_cfg;
			dol_pkg::DOL_BSYNC_CFG_ADDR: st_nxt.rdata = st_r.bsync_cfg;
			default: st_nxt.rdata = 8'h00;
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r.freq_cfg <= dol_pkg::DOL_FREQ_CFG_RST; // [R2] [R3] [R4]
			st_r.bsync_cfg <= dol_pkg::DOL_BSYNC_CFG_RST; // [R6] [R7] [R8] [R9] [R10]
			st_r.synced <= 1'b0;
			st_r.rdata <= 8'h00;
		end else begin
			st_r <= st_nxt;
		end
	end

	// The gain switch is combinational on the sync pulse so the loop sees it without delay.
	assign post_active = st_r.synced || sync_det_i; // [R12]
	assign freq_pre_units = {1'b0, freq_gain_pre_sync, 1'b0} + 4'h2; // [R2]
	assign int_pre_units = {1'b0, clk_integral_gain_pre_sync, 1'b0} + 4'h2; // [R6]
	assign prop_pre_units = {1'b0, clk_proportional_gain_pre_sync} + 3'h1; // [R7]

	always_comb begin
		freq_gain_o = freq_pre_units;
		clk_int_gain_o = int_pre_units;
		clk_prop_gain_o = prop_pre_units;
		if (post_active && freq_gain_post_sync) begin
			freq_gain_o = dol_pkg::DOL_HALF_GAIN; // [R3]
		end
		if (post_active && clk_integral_gain_post_sync) begin
			clk_int_gain_o = dol_pkg::DOL_HALF_GAIN; // [R8]
		end
		if (post_active && clk_proportional_gain_post_sync) begin
			clk_prop_gain_o = dol_pkg::DOL_UNIT_GAIN; // [R9]
		end
	end

	// Code 00 turns compensation off; otherwise the clamp is bandwidth over two to this power.
	assign freq_comp_en_o = (freq_offset_limit != 2'b00); // [R4]
	assign freq_limit_log2_o = 2'(3'h4 - {1'b0, freq_offset_limit}); // [R4]
	// Rate clamp in units of 1/32 of the data rate.
	assign rate_limit_o = (data_rate_offset_limit == 2'b00) ? 3'h0 :
		3'(3'h1 << (data_rate_offset_limit - 2'b01)); // [R10]
	// With on-off keying software keeps the limit at 00, so no correction leaks through.
	assign loops_run_o = !loop_gate_on_carrier || cs; // [R1]
	assign carrier_sense_o = cs;
	assign post_sync_o = post_active;
	assign reg_rdata_o = st_r.rdata;

	sequence s_sync_quiet;
		sync_det_i ##1 !rx_start_i [*2];
	endsequence

	property p_gate;
		@(posedge mclk_i) disable iff (!rst_b_i)
		(loop_gate_on_carrier && !carrier_sense_o) |-> !loops_run_o;
	endproperty
	a_gate: assert property (p_gate) else $error("loops ran while gated"); // [R1]

	property p_free;
		@(posedge mclk_i) disable iff (!rst_b_i)
		!loop_gate_on_carrier |-> loops_run_o;
	endproperty
	a_free: assert property (p_free) else $error("loops frozen without gating"); // [R1]

	property p_freq_pre;
		@(posedge mclk_i) disable iff (!rst_b_i)
		!post_sync_o |-> (freq_gain_o == 4'(2 * (freq_gain_pre_sync + 1)));
	endproperty
	a_freq_pre: assert property (p_freq_pre) else $error("wrong pre-sync frequency gain"); // [R2]

	property p_freq_post;
		@(posedge mclk_i) disable iff (!rst_b_i)
		s_sync_quiet |-> (post_sync_o && (freq_gain_o ==
			(freq_gain_post_sync ? 4'h1 : freq_pre_units)));
	endproperty
	a_freq_post: assert property (p_freq_post) else $error("wrong post-sync frequency gain"); // [R3]

	property p_freq_limit;
		@(posedge mclk_i) disable iff (!rst_b_i)
		(freq_offset_limit == 2'b01) |-> (freq_comp_en_o && (freq_limit_log2_o == 2'd3));
	endproperty
	a_freq_limit: assert property (p_freq_limit) else $error("wrong frequency clamp"); // [R4]

	property p_int;
		@(posedge mclk_i) disable iff (!rst_b_i)
		(post_sync_o && clk_integral_gain_post_sync) |-> (clk_int_gain_o == 4'h1);
	endproperty
	a_int: assert property (p_int) else $error("wrong post-sync integral gain"); // [R8]

	property p_prop_pre;
		@(posedge mclk_i) disable iff (!rst_b_i)
		!post_sync_o |-> (clk_prop_gain_o == 3'(clk_proportional_gain_pre_sync + 1));
	endproperty
	a_prop_pre: assert property (p_prop_pre) else $error("wrong pre-sync proportional gain"); // [R7]

	property p_int_pre;
		@(posedge mclk_i) disable iff (!rst_b_i)
		!post_sync_o |-> (clk_int_gain_o == 4'(2 * (clk_integral_gain_pre_sync + 1)));
	endproperty
	a_int_pre: assert property (p_int_pre) else $error("wrong pre-sync integral gain"); // [R6]

	property p_prop_post;
		@(posedge mclk_i) disable iff (!rst_b_i)
		(post_sync_o && clk_proportional_gain_post_sync) |-> (clk_prop_gain_o == 3'h1);
	endproperty
	a_prop_post: assert property (p_prop_post) else $error("wrong post-sync proportional gain"); // [R9]

	property p_rate;
		@(posedge mclk_i) disable iff (!rst_b_i)
		(data_rate_offset_limit == 2'b11) |-> (rate_limit_o == 3'h4);
	endproperty
	a_rate: assert property (p_rate) else $error("wrong data rate clamp"); // [R10]

	property p_revert;
		@(posedge mclk_i) disable iff (!rst_b_i)
		(rx_start_i && !sync_det_i) ##1 !sync_det_i |-> !post_sync_o;
	endproperty
	a_revert: assert property (p_revert) else $error("post-sync gains kept after new reception"); // [R12]

	property p_write;
		@(posedge mclk_i) disable iff (!rst_b_i)
		(reg_wr_i && (reg_addr_i == dol_pkg::DOL_BSYNC_CFG_ADDR)) |=>
			(st_r.bsync_cfg == $past(reg_wdata_i));
	endproperty
	a_write: assert property (p_write) else $error("configuration write lost"); // [R6]
endmodule

// *** tb.sv ***
// Self-checking testbench for the offset loop configuration block.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [5:0] reg_addr_i = 6'h00;
	logic reg_wr_i = 1'b0;
	logic [7:0] reg_wdata_i = 8'h00;
	logic [7:0] reg_rdata_o;
	logic rx_start_i = 1'b0;
	logic sync_det_i = 1'b0;
	logic rssi_valid_i = 1'b0;
	logic signed [7:0] rssi_i = 8'sh00;
	logic signed [7:0] cs_abs_thr_i = 8'sh10;
	logic [7:0] cs_rel_thr_i = 8'h00;
	logic carrier_sense_o, loops_run_o, post_sync_o, freq_comp_en_o;
	logic [3:0] freq_gain_o, clk_int_gain_o;
	logic [1:0] freq_limit_log2_o;
	logic [2:0] clk_prop_gain_o, rate_limit_o;
	logic [7:0] fr = 8'h36;
	logic [7:0] bs = 8'h6C;
	logic synced = 1'b0;
	logic cs_m = 1'b0;
	logic signed [7:0] rssi_ref = 8'sh00;
	int err_total = 0;
	int num_checks = 0;
	dol_offset_loop_cfg uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
		.reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.rx_start_i(rx_start_i), .sync_det_i(sync_det_i), .rssi_valid_i(rssi_valid_i),
		.rssi_i(rssi_i), .cs_abs_thr_i(cs_abs_thr_i), .cs_rel_thr_i(cs_rel_thr_i),
		.carrier_sense_o(carrier_sense_o), .loops_run_o(loops_run_o),
		.post_sync_o(post_sync_o), .freq_gain_o(freq_gain_o), .freq_comp_en_o(freq_comp_en_o),
		.freq_limit_log2_o(freq_limit_log2_o), .clk_int_gain_o(clk_int_gain_o),
		.clk_prop_gain_o(clk_prop_gain_o), .rate_limit_o(rate_limit_o));
	always #20 mclk_i = ~mclk_i;
	task automatic end_sim;
		if (err_total == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick;
		@(posedge mclk_i);
		#1;
	endtask
	// Gains, clamps and enables as seen with post-sync state ps.
	function automatic logic [16:0] exp_out(input logic ps);
		logic [3:0] fg, ig;
		logic [2:0] pg, rl;
		fg = (ps && fr[2]) ? 4'h1 : {1'b0, fr[4:3], 1'b0} + 4'h2;
		ig = (ps && bs[3]) ? 4'h1 : {1'b0, bs[7:6], 1'b0} + 4'h2;
		pg = (ps && bs[2]) ? 3'h1 : {1'b0, bs[5:4]} + 3'h1;
		rl = (bs[1:0] == 2'b11) ? 3'h4 : {1'b0, bs[1:0]};
		return {fg, fr[1:0] != 2'b00, 2'b00 - fr[1:0], ig, pg, rl};
	endfunction
	// The clamp exponent carries no meaning while compensation is off, so it is masked then.
	function automatic logic [16:0] got_out;
		return {freq_gain_o, freq_comp_en_o, (fr[1:0] == 2'b00) ? 2'b00 : freq_limit_log2_o,
			clk_int_gain_o, clk_prop_gain_o, rate_limit_o};
	endfunction
	function automatic logic exp_cs(input logic signed [7:0] r);
		int d;
		d = int'(r) - int'(rssi_ref);
		return (r > cs_abs_thr_i) || (cs_rel_thr_i != 8'h00 && d >= int'(cs_rel_thr_i));
	endfunction
	task automatic check_all(input logic sd);
		chk(got_out(), exp_out(synced | sd));
		chk(post_sync_o, synced | sd);
		chk(loops_run_o, !fr[5] | cs_m);
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		tick();
		reg_wr_i = 1'b0;
		if (a == 6'h19) fr = d & 8'h3F;
		if (a == 6'h18) bs = d;
		// One idle edge keeps back-to-back writes from pulsing the strobe within one step.
		tick();
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		reg_addr_i = a;
		tick();
		chk(reg_rdata_o, e);
	endtask
	task automatic rx_go(input logic [7:0] r, input logic sd);
		rssi_i = r;
		rx_start_i = 1'b1;
		sync_det_i = sd;
		tick();
		rx_start_i = 1'b0;
		sync_det_i = 1'b0;
		rssi_ref = r;
		cs_m = 1'b0;
		synced = sd;
		chk(carrier_sense_o, 1'b0);
		check_all(1'b0);
	endtask
	task automatic sample(input logic [7:0] r);
		rssi_i = r;
		rssi_valid_i = 1'b1;
		tick();
		rssi_valid_i = 1'b0;
		cs_m = exp_cs(r);
		chk(carrier_sense_o, cs_m);
		check_all(1'b0);
		tick();
	endtask
	initial begin
		logic sd;
		void'($urandom(32'h7dd5));
		repeat (4) @(posedge mclk_i);
		#1;
		rst_b_i = 1'b1;
		check_all(1'b0);
		rd(6'h19, 8'h36);
		rd(6'h18, 8'h6C);
		wr(6'h05, 8'hFF);
		rd(6'h05, 8'h00);
		rd(6'h19, 8'h36);
		for (int i = 0; i < 40; i++) begin
			wr(6'h19, 8'($urandom));
			wr(6'h18, 8'($urandom));
			rd(6'h19, fr);
			rd(6'h18, bs);
			sd = 1'($urandom);
			sync_det_i = sd;
			#1;
			check_all(sd);
			tick();
			sync_det_i = 1'b0;
			synced = synced | sd;
			check_all(1'b0);
			tick();
			check_all(1'b0);
			rx_go(8'($urandom), 1'($urandom));
		end
		// Hand-picked threshold corners, then random ones.
		wr(6'h19, 8'h3F);
		cs_abs_thr_i = 8'sh10;
		rx_go(8'hEC, 1'b0);
		sample(8'h10);
		sample(8'h11);
		cs_rel_thr_i = 8'h08;
		rx_go(8'hEC, 1'b0);
		sample(8'hF3);
		sample(8'hF4);
		wr(6'h19, 8'h1F);
		sample(8'h80);
		// On-off keying setup: software leaves the offset limit at 00, so compensation is off.
		wr(6'h19, 8'h1C);
		chk(freq_comp_en_o, 1'b0);
		check_all(1'b0);
		for (int i = 0; i < 20; i++) begin
			wr(6'h19, 8'($urandom));
			cs_abs_thr_i = 8'($urandom);
			cs_rel_thr_i = 8'($urandom % 16);
			rx_go(8'($urandom), 1'b0);
			repeat (4) sample(8'($urandom));
		end
		end_sim();
	end
endmodule
